/* core/bltic_pkg.sv */
// Shared constants, types and register layout of the backlight timeout and fault interrupt bank.
//
// Behaviour
// - Short-circuit flag with its enable bit 4 set raises the host interrupt.
// - Thermal flag with its enable bit 3 set raises the host interrupt.
// - Overvoltage flag with its enable bit 2 set raises the host interrupt.
// - A disabled fault raises no interrupt but its flag still sets and holds.
// - Interrupt enable bits 7 to 5 and 1 to 0 are reserved.
// - Law field 00 linear, 01 square, 10 and 11 cubic variants.
// - Configuration bit 0 turns the backlight fade override on or off.
// - Sink select bit one makes a diode independent; zero ties it to backlight.
// - Off timeout is seven bits of whole seconds; zero disables it.
// - Off timeout expiry turns the backlight off.
// - With dim timeout enabled, off timeout counts only after dim completes.
// - Dim timeout is seven bits of whole seconds; zero disables it.
// - Dim timeout expiry switches the backlight to its dim level.
// - Dim timeout starts counting only once maximum current is reached.
// - Dim expiry sets the dim bit; software may set it only with backlight enabled.
// - Backlight runs only when backlight enable and active mode bits are both one.
// - A fault flag clears only by writing one; zero or reading leaves it.
package bltic_pkg;

	localparam logic [7:0] ADDR_MODE = 8'h01;
	localparam logic [7:0] ADDR_STATUS = 8'h02;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h03;
	localparam logic [7:0] ADDR_CFG = 8'h04;
	localparam logic [7:0] ADDR_SINK = 8'h05;
	localparam logic [7:0] ADDR_OFF_TMR = 8'h06;
	localparam logic [7:0] ADDR_DIM_TMR = 8'h07;

	localparam int unsigned BIT_BL_ON = 0;
	localparam int unsigned BIT_DIM = 4;
	localparam int unsigned BIT_ACTIVE = 5;
	localparam int unsigned BIT_SHORT = 4;
	localparam int unsigned BIT_THERM = 3;
	localparam int unsigned BIT_OVP = 2;
	localparam int unsigned BIT_FADE_OVR = 0;
	localparam int unsigned LAW_LSB = 1;
	localparam int unsigned LAW_MSB = 2;

	localparam logic [7:0] MODE_MASK = 8'h31;
	localparam logic [7:0] FLAG_MASK = 8'h1c;
	localparam logic [7:0] CFG_MASK = 8'h07;
	localparam logic [7:0] SINK_MASK = 8'h7f;
	localparam logic [7:0] TMR_MASK = 8'h7f;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] READ_NONE = 8'h00;

	localparam int unsigned NUM_DIODES = 7;
	localparam int unsigned TMR_W = 7;
	localparam logic [TMR_W-1:0] TMR_OFF = 7'h00;

	localparam int unsigned SECOND_NS = 32'd1000000000;
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned TICK_CYCLES_DEF = SECOND_NS / CLK_PERIOD_NS;
	localparam int unsigned PRESC_W = 28;

	typedef enum logic [1:0] {
		BLTIC_LAW_LINEAR,
		BLTIC_LAW_SQUARE,
		BLTIC_LAW_CUBIC10,
		BLTIC_LAW_CUBIC11
	} bltic_law_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} bltic_req_t;

	typedef struct packed {
		logic short_circuit;
		logic thermal;
		logic overvoltage;
	} bltic_fault_t;

	typedef struct packed {
		logic backlight_active;
		logic dim_level;
		logic fade_override;
		bltic_law_t law;
		logic [NUM_DIODES-1:0] sink_independent;
		logic [NUM_DIODES-1:0] sink_group_on;
	} bltic_drive_t;

endpackage

/* core/bltic_sec_timer.sv */
// Seconds timer with its own prescaler, giving a one-cycle pulse when the count is reached.
`timescale 1ns/1ps
module bltic_sec_timer
	import bltic_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic run,
	input wire logic [TMR_W-1:0] limit,
	output logic expired
);

	logic [PRESC_W-1:0] pre_q, pre_d;
	logic [TMR_W-1:0] sec_q, sec_d;
	logic done_q, done_d;
	logic exp_q, exp_d;

	// The prescaler restarts whenever run drops, so every timeout lasts whole seconds.
	always_comb begin
		pre_d = pre_q;
		sec_d = sec_q;
		done_d = done_q;
		exp_d = 1'b0;
		if (!run) begin
			pre_d = '0;
			sec_d = '0;
			done_d = 1'b0;
		end else if (!done_q) begin
			if (pre_q == PRESC_W'(TICK_CYCLES - 1)) begin
				pre_d = '0;
				sec_d = sec_q + 7'h01;
				if (sec_d == limit) begin
					done_d = 1'b1;
					exp_d = 1'b1;
				end
			end else begin
				pre_d = pre_q + 28'h0000001;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pre_q <= '0;
			sec_q <= '0;
			done_q <= 1'b0;
			exp_q <= 1'b0;
		end else begin
			pre_q <= pre_d;
			sec_q <= sec_d;
			done_q <= done_d;
			exp_q <= exp_d;
		end
	end

	assign expired = exp_q;

	tick_count_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		exp_q |-> sec_q == limit && $past(pre_q) == PRESC_W'(TICK_CYCLES - 1))
		else $error("Timer expired off a second boundary.");

endmodule

/* core/bltic_ctrl.sv */
// Register bank, fault flags, interrupt and backlight dim and off sequencing.
`timescale 1ns/1ps
module bltic_ctrl
	import bltic_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire bltic_req_t reg_req,
	output logic [7:0] reg_rdata,
	input wire bltic_fault_t fault_raw,
	input wire logic at_max_current,
	output logic host_irq,
	output bltic_drive_t drive
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RAMP,
		ST_WAIT_DIM,
		ST_WAIT_OFF,
		ST_HOLD
	} bltic_state_t;

	function automatic logic hit(input bltic_req_t req, input logic [7:0] addr);
		hit = req.wr && (req.addr == addr);
	endfunction

	// Fault detectors are asynchronous to the bank clock.
	bltic_fault_t fault_meta_q, fault_sync_q;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			fault_meta_q <= '0;
			fault_sync_q <= '0;
		end else begin
			fault_meta_q <= fault_raw;
			fault_sync_q <= fault_meta_q;
		end
	end

	logic [7:0] mode_q, mode_d;
	logic [7:0] irq_en_q, irq_en_d;
	logic [7:0] cfg_q, cfg_d;
	logic [7:0] sink_q, sink_d;
	logic [7:0] off_q, off_d;
	logic [7:0] dim_q, dim_d;
	logic [7:0] flag_q, flag_d;
	logic [7:0] flag_clr;
	logic [7:0] flag_set;
	logic dim_expired, off_expired;
	logic dim_run, off_run;
	logic backlight_on;

	assign backlight_on = mode_q[BIT_BL_ON] && mode_q[BIT_ACTIVE];

	always_comb begin
		flag_set = '0;
		flag_set[BIT_SHORT] = fault_sync_q.short_circuit;
		flag_set[BIT_THERM] = fault_sync_q.thermal;
		flag_set[BIT_OVP] = fault_sync_q.overvoltage;
		flag_clr = hit(reg_req, ADDR_STATUS) ? (reg_req.wdata & FLAG_MASK) : '0;
		// A fault present in the clearing cycle keeps its flag set.
		flag_d = (flag_q & ~flag_clr) | flag_set;
		irq_en_d = irq_en_q;
		cfg_d = cfg_q;
		sink_d = sink_q;
		off_d = off_q;
		dim_d = dim_q;
		if (hit(reg_req, ADDR_IRQ_EN)) begin
			irq_en_d = reg_req.wdata & FLAG_MASK;
		end
		if (hit(reg_req, ADDR_CFG)) begin
			cfg_d = reg_req.wdata & CFG_MASK;
		end
		if (hit(reg_req, ADDR_SINK)) begin
			sink_d = reg_req.wdata & SINK_MASK;
		end
		if (hit(reg_req, ADDR_OFF_TMR)) begin
			off_d = reg_req.wdata & TMR_MASK;
		end
		if (hit(reg_req, ADDR_DIM_TMR)) begin
			dim_d = reg_req.wdata & TMR_MASK;
		end
		mode_d = mode_q;
		if (hit(reg_req, ADDR_MODE)) begin
			mode_d = reg_req.wdata & MODE_MASK;
		end
		// Hardware events are applied after the software write so that they win.
		if (dim_expired) begin
			mode_d[BIT_DIM] = 1'b1;
		end
		if (off_expired) begin
			mode_d[BIT_BL_ON] = 1'b0;
		end
		if (!mode_d[BIT_BL_ON]) begin
			mode_d[BIT_DIM] = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mode_q <= REG_RESET;
			irq_en_q <= REG_RESET;
			cfg_q <= REG_RESET;
			sink_q <= REG_RESET;
			off_q <= REG_RESET;
			dim_q <= REG_RESET;
			flag_q <= REG_RESET;
		end else begin
			mode_q <= mode_d;
			irq_en_q <= irq_en_d;
			cfg_q <= cfg_d;
			sink_q <= sink_d;
			off_q <= off_d;
			dim_q <= dim_d;
			flag_q <= flag_d;
		end
	end

	// Interrupt request.
	logic irq_q, irq_d;

	always_comb begin
		irq_d = 1'b0;
		if (flag_q[BIT_SHORT] && irq_en_q[BIT_SHORT]) begin
			irq_d = 1'b1;
		end
		if (flag_q[BIT_THERM] && irq_en_q[BIT_THERM]) begin
			irq_d = 1'b1;
		end
		if (flag_q[BIT_OVP] && irq_en_q[BIT_OVP]) begin
			irq_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	assign host_irq = irq_q;

	// Dim and off sequencing.
	bltic_state_t state_q, state_d;
	logic [TMR_W-1:0] dim_t, off_t;

	assign dim_t = dim_q[TMR_W-1:0];
	assign off_t = off_q[TMR_W-1:0];

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (backlight_on) begin
					state_d = ST_RAMP;
				end
			end
			ST_RAMP: begin
				if (at_max_current) begin
					if (dim_t != TMR_OFF) begin
						state_d = ST_WAIT_DIM;
					end else if (off_t != TMR_OFF) begin
						state_d = ST_WAIT_OFF;
					end else begin
						state_d = ST_HOLD;
					end
				end
			end
			ST_WAIT_DIM: begin
				if (dim_expired || dim_t == TMR_OFF) begin
					state_d = (off_t != TMR_OFF) ? ST_WAIT_OFF : ST_HOLD;
				end
			end
			ST_WAIT_OFF: begin
				if (off_expired || off_t == TMR_OFF) begin
					state_d = ST_HOLD;
				end
			end
			ST_HOLD: begin
				state_d = ST_HOLD;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		if (!backlight_on) begin
			state_d = ST_IDLE;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	assign dim_run = (state_q == ST_WAIT_DIM) && (dim_t != TMR_OFF) && backlight_on;
	assign off_run = (state_q == ST_WAIT_OFF) && (off_t != TMR_OFF) && backlight_on;

	bltic_sec_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_dim_timer (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.run(dim_run),
		.limit(dim_t),
		.expired(dim_expired)
	);

	bltic_sec_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_off_timer (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.run(off_run),
		.limit(off_t),
		.expired(off_expired)
	);

	// Drive outputs toward the current sinks and fade engine.
	bltic_drive_t drive_q, drive_d;
	logic [NUM_DIODES-1:0] sink_ind;
	logic [NUM_DIODES-1:0] sink_grp;

	generate
		for (genvar i = 0; i < NUM_DIODES; i++) begin : g_sink
			assign sink_ind[i] = sink_q[i];
			assign sink_grp[i] = !sink_q[i] && backlight_on;
		end
	endgenerate

	always_comb begin
		drive_d.backlight_active = backlight_on;
		drive_d.dim_level = backlight_on && mode_q[BIT_DIM];
		drive_d.fade_override = cfg_q[BIT_FADE_OVR];
		drive_d.law = bltic_law_t'(cfg_q[LAW_MSB:LAW_LSB]);
		drive_d.sink_independent = sink_ind;
		drive_d.sink_group_on = sink_grp;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			drive_q <= '0;
		end else begin
			drive_q <= drive_d;
		end
	end

	assign drive = drive_q;

	// Read port: data appears the cycle after the read strobe; reads have no side effects.
	logic [7:0] rdata_q, rdata_d;

	always_comb begin
		rdata_d = rdata_q;
		if (reg_req.rd) begin
			if (reg_req.addr == ADDR_MODE) begin
				rdata_d = mode_q;
			end else if (reg_req.addr == ADDR_STATUS) begin
				rdata_d = flag_q;
			end else if (reg_req.addr == ADDR_IRQ_EN) begin
				rdata_d = irq_en_q;
			end else if (reg_req.addr == ADDR_CFG) begin
				rdata_d = cfg_q;
			end else if (reg_req.addr == ADDR_SINK) begin
				rdata_d = sink_q;
			end else if (reg_req.addr == ADDR_OFF_TMR) begin
				rdata_d = off_q;
			end else if (reg_req.addr == ADDR_DIM_TMR) begin
				rdata_d = dim_q;
			end else begin
				rdata_d = READ_NONE;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= READ_NONE;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	sequence dim_done_s;
		dim_expired ##1 mode_q[BIT_DIM];
	endsequence

	sequence off_done_s;
		off_expired ##1 !mode_q[BIT_BL_ON];
	endsequence

	short_irq_a: assert property (flag_q[BIT_SHORT] && irq_en_q[BIT_SHORT] |=> host_irq)
		else $error("Short fault enabled but no interrupt.");
	thermal_irq_a: assert property (flag_q[BIT_THERM] && irq_en_q[BIT_THERM] |=> host_irq)
		else $error("Thermal fault enabled but no interrupt.");
	ovp_irq_a: assert property (flag_q[BIT_OVP] && irq_en_q[BIT_OVP] |=> host_irq)
		else $error("Overvoltage fault enabled but no interrupt.");
	masked_quiet_a: assert property ((flag_q & irq_en_q) == '0 |=> !host_irq)
		else $error("Interrupt raised with every fault masked.");
	flag_hold_a: assert property (flag_q[BIT_THERM] && !flag_clr[BIT_THERM] |=> flag_q[BIT_THERM])
		else $error("Fault flag dropped without a clearing write.");
	reserved_zero_a: assert property ((irq_en_q & ~FLAG_MASK) == '0)
		else $error("Reserved enable bits hold a one.");
	law_decode_a: assert property (##1 drive.law == bltic_law_t'($past(cfg_q[LAW_MSB:LAW_LSB])))
		else $error("Transfer law does not follow the configuration field.");
	fade_ovr_a: assert property (##1 drive.fade_override == $past(cfg_q[BIT_FADE_OVR]))
		else $error("Fade override does not follow its bit.");
	sink_split_a: assert property ((drive.sink_group_on & drive.sink_independent) == '0)
		else $error("Diode both independent and in the backlight group.");
	timer_zero_a: assert property ($past(dim_t) == TMR_OFF |-> !dim_expired)
		else $error("Dim timeout expired while disabled.");
	off_expiry_a: assert property (off_expired |-> off_done_s ##1 !drive.backlight_active)
		else $error("Backlight still on after off timeout.");
	dim_first_a: assert property (off_run && dim_t != TMR_OFF |-> mode_q[BIT_DIM])
		else $error("Off timeout counting before dim timeout ended.");
	dim_expiry_a: assert property (dim_expired |-> dim_done_s ##1 drive.dim_level)
		else $error("Dim level not reached after dim timeout.");
	dim_after_max_a: assert property ($rose(dim_run) |-> $past(at_max_current))
		else $error("Dim timeout started before maximum current.");
	dim_needs_on_a: assert property (mode_q[BIT_DIM] |-> mode_q[BIT_BL_ON])
		else $error("Dim bit set with backlight disabled.");
	enable_pair_a: assert property (drive.backlight_active |-> $past(backlight_on))
		else $error("Backlight active without enable and active mode.");
	clear_one_a: assert property (flag_clr[BIT_OVP] && !fault_sync_q.overvoltage
		|=> !flag_q[BIT_OVP])
		else $error("Writing one did not clear the flag.");

endmodule

/* testbench/bltic_host_model.sv */
// Host-side model that posts register requests on the block's strobe bus.
`timescale 1ns/1ps
module bltic_host_model
	import bltic_pkg::*;
(
	input wire logic clk_sys,
	input wire logic [7:0] reg_rdata,
	output bltic_req_t reg_req
);
	initial begin
		reg_req = '0;
	end
	// Released address and data are inverted so a stale value never looks valid.
	task automatic idle();
		reg_req.wr = 1'b0;
		reg_req.rd = 1'b0;
		reg_req.addr = ~reg_req.addr;
		reg_req.wdata = ~reg_req.wdata;
	endtask
	// A one written to a flag position clears that flag.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#1;
		reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys);
		#1;
		idle();
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		#1;
		reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_sys);
		#1;
		idle();
		@(posedge clk_sys);
		#1;
		d = reg_rdata;
	endtask
endmodule

/* testbench/bltic_ctrl_tb.sv */
// Self-checking testbench of the backlight timeout and fault interrupt bank.
`timescale 1ns/1ps
module bltic_ctrl_tb;
	import bltic_pkg::*;
	localparam int unsigned TK = 10;
	logic clk_sys;
	logic nrst;
	bltic_req_t reg_req;
	logic [7:0] reg_rdata;
	bltic_fault_t fault_raw;
	logic at_max_current;
	logic host_irq;
	bltic_drive_t drive;
	int fails;
	int tests_run;
	int n;
	logic [7:0] msk [5] = '{8'h1c, 8'h07, 8'h7f, 8'h7f, 8'h7f};

	bltic_ctrl #(.TICK_CYCLES(TK)) u_bltic_ctrl (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.reg_req(reg_req),
		.reg_rdata(reg_rdata),
		.fault_raw(fault_raw),
		.at_max_current(at_max_current),
		.host_irq(host_irq),
		.drive(drive)
	);

	bltic_host_model u_bltic_host_model (
		.clk_sys(clk_sys),
		.reg_rdata(reg_rdata),
		.reg_req(reg_req)
	);

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic conclude();
		if (fails == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_bltic_host_model.wr(a, d);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_bltic_host_model.rd(a, d);
		chk(32'(d), 32'(e));
	endtask

	// Counts cycles until dim (sel 0) or backlight off (sel 1) shows, then checks the span.
	task automatic wait_for(input int sel, input int lo, input int hi);
		n = 0;
		while (((sel == 0) ? drive.dim_level !== 1'b1 : drive.backlight_active !== 1'b0)
				&& n < 200) begin
			cyc(1);
			n++;
		end
		chk(32'(n >= lo && n <= hi), 32'd1);
	endtask

	initial begin
		fails = 0;
		tests_run = 0;
		nrst = 1'b0;
		fault_raw = '0;
		at_max_current = 1'b0;
		fork
			begin
				#40000;
				fails++;
				conclude();
			end
		join_none
		repeat (2) @(posedge clk_sys);
		#1;
		nrst = 1'b1;
		chk(32'(drive), 32'd0);
		for (int a = 0; a < 9; a++) begin
			rchk(8'(a), 8'h00);
		end
		foreach (msk[i]) begin
			wr(8'(3 + i), 8'hff);
			rchk(8'(3 + i), msk[i]);
		end
		wr(8'h10, 8'hff);
		rchk(8'h10, 8'h00);
		for (int l = 0; l < 4; l++) begin
			for (int f = 0; f < 2; f++) begin
				wr(ADDR_CFG, 8'((l << 1) | f));
				cyc(2);
				chk(32'(drive.law), 32'(l));
				chk(32'(drive.fade_override), 32'(f));
			end
		end
		wr(ADDR_SINK, 8'h55);
		cyc(2);
		chk(32'(drive.sink_independent), 32'h55);
		// Each fault with its own enable off and the other enables on, then with its own enable on.
		for (int j = 0; j < 3; j++) begin
			for (int e = 0; e < 2; e++) begin
				wr(ADDR_IRQ_EN, (e != 0) ? 8'(4 << j) : 8'(8'h1c & ~(4 << j)));
				fault_raw = 3'(1 << j);
				cyc(6);
				fault_raw = '0;
				cyc(4);
				chk(32'(host_irq), 32'(e));
				wr(ADDR_STATUS, 8'(~(4 << j)));
				rchk(ADDR_STATUS, 8'(4 << j));
				chk(32'(host_irq), 32'(e));
				wr(ADDR_STATUS, 8'(4 << j));
				rchk(ADDR_STATUS, 8'h00);
				chk(32'(host_irq), 32'd0);
			end
		end
		wr(ADDR_MODE, 8'h01);
		cyc(2);
		chk(32'(drive.backlight_active), 32'd0);
		wr(ADDR_MODE, 8'h30);
		rchk(ADDR_MODE, 8'h20);
		// Dim then off sequence, held back until maximum current.
		wr(ADDR_DIM_TMR, 8'h02);
		wr(ADDR_OFF_TMR, 8'h03);
		wr(ADDR_MODE, 8'h21);
		cyc(40);
		chk(32'(drive.backlight_active), 32'd1);
		chk(32'(drive.dim_level), 32'd0);
		chk(32'(drive.sink_group_on), 32'h2a);
		at_max_current = 1'b1;
		wait_for(0, 20, 34);
		rchk(ADDR_MODE, 8'h31);
		wait_for(1, 27, 44);
		rchk(ADDR_MODE, 8'h20);
		chk(32'(drive.sink_group_on), 32'd0);
		at_max_current = 1'b0;
		// Dim forced by software, dim timeout off: off counts from maximum current.
		wr(ADDR_DIM_TMR, 8'h00);
		wr(ADDR_OFF_TMR, 8'h02);
		wr(ADDR_MODE, 8'h31);
		rchk(ADDR_MODE, 8'h31);
		chk(32'(drive.dim_level), 32'd1);
		at_max_current = 1'b1;
		wait_for(1, 18, 36);
		at_max_current = 1'b0;
		// Both timeouts disabled: backlight holds.
		wr(ADDR_OFF_TMR, 8'h00);
		wr(ADDR_MODE, 8'h21);
		at_max_current = 1'b1;
		cyc(150);
		chk(32'(drive.backlight_active), 32'd1);
		conclude();
	end
endmodule
